// ---- src/rpd_top.sv ----
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1: cpu ram access 8, 16, 32 bits
// R2: dma ram access 8 or 16 bits
// R3: every ram access takes one state
// R4: ram enable on steers range to ram
// R5: ram disabled: reads undefined, writes ignored
// R6: ram contents held in sleep, standby
// R7: hardware standby keeps ram only if disabled
// R8: standby pin low halts all, inits ports
// R9: sleep with select one enters software standby
// R10: sleep with select zero halts cpu only
// R11: port float bit floats ports in standby
// R12: select bit refuses set while watchdog runs
// R13: float bit refuses set while watchdog runs
// R14: standby register resets 1F, fixed low bits
// R15: system register resets 01, only bit0 writable
// R16: both registers byte wide, 3/2 states; the plain strobed port here serves either register in one cycle
// R17: no ram access right after disabling
// R18: read back system register after enabling
// R19: standby exit needs pin high, then reset
// R20: nmi restarts watchdog clock, overflow resumes
// R21: reserved bits ignore writes
module rpd_top
  import rpd_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  // register port
  input  wire logic [31:0] REG_ADDR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [7:0]  REG_RDATA_OUT,
  // cpu ram port
  input  wire logic        CPU_REQ_IN,
  input  wire logic        CPU_WE_IN,
  input  wire logic [1:0]  CPU_SIZE_IN,
  input  wire logic [31:0] CPU_ADDR_IN,
  input  wire logic [31:0] CPU_WDATA_IN,
  output logic             CPU_ACK_OUT,
  output logic             CPU_HIT_OUT,
  // dma ram port
  input  wire logic        DMA_REQ_IN,
  input  wire logic        DMA_WE_IN,
  input  wire logic [1:0]  DMA_SIZE_IN,
  input  wire logic [31:0] DMA_ADDR_IN,
  input  wire logic [31:0] DMA_WDATA_IN,
  output logic             DMA_ACK_OUT,
  output logic             DMA_SIZE_ERR_OUT,
  output logic      [31:0] RAM_RDATA_OUT,
  // power-down control
  input  wire logic        HW_STANDBY_N_IN,
  input  wire logic        WDT_RUN_IN,
  input  wire logic        SLEEP_IN,
  input  wire logic        IRQ_IN,
  input  wire logic        DMA_ADDR_ERR_IN,
  input  wire logic        NMI_EDGE_IN,
  input  wire logic        WDT_OVF_IN,
  output logic      [2:0]  PWR_MODE_OUT,
  output logic             CPU_HALT_OUT,
  output logic             CHIP_CLK_RUN_OUT,
  output logic             WDT_CLK_RUN_OUT,
  output logic             PERIPH_RUN_OUT,
  output logic             OSC_RUN_OUT,
  output logic             PORT_FLOAT_OUT,
  output logic             PORT_INIT_OUT,
  output logic             RAM_RETAIN_OUT,
  output logic             NMI_START_OUT,
  output logic             WAKE_START_OUT
);

  import rpd_pkg::*;

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  localparam logic [31:0] RAM_BASE = LARGE_VARIANT ? RAM_BASE_LARGE : RAM_BASE_SMALL;

  logic       ram_enable_bit_reg;
  logic       standby_select_bit_reg;
  logic       port_float_bit_reg;
  logic [7:0] system_control_register;
  logic [7:0] standby_control_register;
  rpd_pwr_e   pwr_reg;
  rpd_pwr_e   pwr_next;
  logic       ram_keep_reg;

  rpd_ram_if  ram_bus ();

  rpd_ram u_ram (
    .clk_in (CLK_IN),
    .port   (ram_bus.mem)
  );

  // byte-wide views; reserved bits are constants so writes cannot move them
  assign system_control_register  = {7'h00, ram_enable_bit_reg};  // R15 R21
  assign standby_control_register = {standby_select_bit_reg, port_float_bit_reg,
                                     STANDBY_FIXED_BITS[5:0]};   // R14 R21

  wire sys_hit = (REG_ADDR_IN == SYSTEM_CONTROL_ADDR);
  wire sby_hit = (REG_ADDR_IN == STANDBY_CONTROL_ADDR);

  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  // system control: only the ram enable is writable
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ram_enable_bit_reg <= SYSTEM_CONTROL_RST[RAM_ENABLE_POS];  // R15
    end else if (REG_WR_IN && sys_hit) begin
      ram_enable_bit_reg <= REG_WDATA_IN[RAM_ENABLE_POS];  // R16
    end
  end

  // standby control: set of select and float refused while watchdog runs
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      standby_select_bit_reg <= STANDBY_CONTROL_RST[STANDBY_SELECT_POS];  // R14
      port_float_bit_reg     <= STANDBY_CONTROL_RST[PORT_FLOAT_POS];
    end else if (REG_WR_IN && sby_hit) begin
      standby_select_bit_reg <= REG_WDATA_IN[STANDBY_SELECT_POS] &
                                (!WDT_RUN_IN | standby_select_bit_reg);  // R12
      port_float_bit_reg     <= REG_WDATA_IN[PORT_FLOAT_POS] &
                                (!WDT_RUN_IN | port_float_bit_reg);      // R13
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= UNMAPPED_READ;
    end else if (REG_RD_IN && sys_hit) begin
      REG_RDATA_OUT <= system_control_register;  // R16
    end else if (REG_RD_IN && sby_hit) begin
      REG_RDATA_OUT <= standby_control_register;  // R16
    end else begin
      REG_RDATA_OUT <= UNMAPPED_READ;
    end
  end

  // -------------------------------------------------------------
  // ram access steering
  // -------------------------------------------------------------
  // byte lanes, big-endian: address 0 of a word is lane 3
  function automatic logic [3:0] lanes(input logic [1:0] size, input logic [1:0] a);
    logic [3:0] be;
    be = 4'h0;
    case (size)
      SIZE_BYTE: be = 4'(4'h8 >> a);
      SIZE_WORD: be = a[0] ? 4'h0 : (a[1] ? 4'h3 : 4'hC);
      SIZE_LONG: be = (a == 2'h0) ? 4'hF : 4'h0;
      default:   be = 4'h0;
    endcase
    return be;
  endfunction

  logic [31:0] cpu_off;
  logic [31:0] dma_off;
  logic        cpu_in_range;
  logic        dma_in_range;
  logic        dma_size_ok;
  logic        cpu_go;
  logic        dma_go;
  logic        cpu_ram;
  logic        dma_ram;

  assign cpu_off      = CPU_ADDR_IN - RAM_BASE;
  assign dma_off      = DMA_ADDR_IN - RAM_BASE;
  assign cpu_in_range = (CPU_ADDR_IN >= RAM_BASE);  // R4
  assign dma_in_range = (DMA_ADDR_IN >= RAM_BASE);
  assign dma_size_ok  = (DMA_SIZE_IN == SIZE_BYTE) || (DMA_SIZE_IN == SIZE_WORD);  // R2

  // cpu served only while running; dma also while the cpu sleeps
  assign cpu_go  = CPU_REQ_IN && (pwr_reg == PWR_RUN);
  assign dma_go  = DMA_REQ_IN && dma_size_ok && !cpu_go &&
                   ((pwr_reg == PWR_RUN) || (pwr_reg == PWR_SLEEP));
  assign cpu_ram = cpu_go && cpu_in_range && ram_enable_bit_reg;  // R4 R5
  assign dma_ram = dma_go && dma_in_range && ram_enable_bit_reg;  // R5

  // one ram port, cpu first; no array access at all in standby
  always_comb begin
    ram_bus.en    = cpu_ram || dma_ram;  // R6
    ram_bus.we    = cpu_ram ? CPU_WE_IN : DMA_WE_IN;
    ram_bus.be    = cpu_ram ? lanes(CPU_SIZE_IN, CPU_ADDR_IN[1:0])
                            : lanes(DMA_SIZE_IN, DMA_ADDR_IN[1:0]);  // R1
    ram_bus.idx   = cpu_ram ? cpu_off[RAM_IDX_W+1:2] : dma_off[RAM_IDX_W+1:2];
    ram_bus.wdata = cpu_ram ? CPU_WDATA_IN : DMA_WDATA_IN;
  end

  // acknowledge every taken access in the next cycle, no waits
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      CPU_ACK_OUT      <= 1'b0;
      DMA_ACK_OUT      <= 1'b0;
      CPU_HIT_OUT      <= 1'b0;
      DMA_SIZE_ERR_OUT <= 1'b0;
    end else begin
      CPU_ACK_OUT      <= cpu_go;  // R3
      DMA_ACK_OUT      <= dma_go;  // R3
      CPU_HIT_OUT      <= cpu_ram;
      DMA_SIZE_ERR_OUT <= DMA_REQ_IN && !dma_size_ok;  // R2
    end
  end

  // read data straight from the array's lane flops, zero unless an enabled read
  assign RAM_RDATA_OUT = ram_bus.rdata;  // R5

  // -------------------------------------------------------------
  // power-down sequencing
  // -------------------------------------------------------------
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PWR_RUN: begin
        if (SLEEP_IN) begin
          pwr_next = standby_select_bit_reg ? PWR_SW_STANDBY : PWR_SLEEP;  // R9 R10
        end
      end
      PWR_SLEEP: begin
        if (IRQ_IN || DMA_ADDR_ERR_IN) begin
          pwr_next = PWR_RUN;  // R10
        end
      end
      PWR_SW_STANDBY: begin
        if (NMI_EDGE_IN) begin
          pwr_next = PWR_OSC_WAIT;  // R20
        end
      end
      PWR_OSC_WAIT: begin
        if (WDT_OVF_IN) begin
          pwr_next = PWR_RUN;  // R20
        end
      end
      PWR_HW_STANDBY: begin
        pwr_next = PWR_HW_STANDBY;  // R19
      end
      default: begin
        pwr_next = PWR_RUN;
      end
    endcase
    if (!HW_STANDBY_N_IN) begin
      pwr_next = PWR_HW_STANDBY;  // R8
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pwr_reg <= PWR_RUN;  // R19
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // ram survives hardware standby only if disabled on entry
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ram_keep_reg <= 1'b1;
    end else if (pwr_next == PWR_HW_STANDBY && pwr_reg != PWR_HW_STANDBY) begin
      ram_keep_reg <= !ram_enable_bit_reg;  // R7
    end
  end

  // status and control outputs follow the next state
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PWR_MODE_OUT     <= 3'h0;
      CPU_HALT_OUT     <= 1'b0;
      CHIP_CLK_RUN_OUT <= 1'b1;
      WDT_CLK_RUN_OUT  <= 1'b1;
      PERIPH_RUN_OUT   <= 1'b1;
      OSC_RUN_OUT      <= 1'b1;
      PORT_FLOAT_OUT   <= 1'b0;
      PORT_INIT_OUT    <= 1'b0;
      RAM_RETAIN_OUT   <= 1'b1;
      NMI_START_OUT    <= 1'b0;
      WAKE_START_OUT   <= 1'b0;
    end else begin
      PWR_MODE_OUT     <= 3'(pwr_next);
      CPU_HALT_OUT     <= (pwr_next != PWR_RUN);  // R10
      CHIP_CLK_RUN_OUT <= (pwr_next == PWR_RUN) || (pwr_next == PWR_SLEEP);  // R9
      WDT_CLK_RUN_OUT  <= (pwr_next == PWR_RUN) || (pwr_next == PWR_SLEEP) ||
                          (pwr_next == PWR_OSC_WAIT);  // R20
      PERIPH_RUN_OUT   <= (pwr_next == PWR_RUN) || (pwr_next == PWR_SLEEP);
      OSC_RUN_OUT      <= (pwr_next != PWR_SW_STANDBY) &&
                          !(pwr_next == PWR_HW_STANDBY && !HW_STANDBY_N_IN);  // R19
      PORT_FLOAT_OUT   <= port_float_bit_reg &&
                          ((pwr_next == PWR_SW_STANDBY) || (pwr_next == PWR_OSC_WAIT));  // R11
      PORT_INIT_OUT    <= (pwr_next == PWR_HW_STANDBY);  // R8
      RAM_RETAIN_OUT   <= (pwr_next == PWR_HW_STANDBY) ?
                          ((pwr_reg == PWR_HW_STANDBY) ? ram_keep_reg : !ram_enable_bit_reg)
                          : 1'b1;  // R6 R7
      NMI_START_OUT    <= (pwr_reg == PWR_OSC_WAIT) && (pwr_next == PWR_RUN);  // R20
      WAKE_START_OUT   <= (pwr_reg == PWR_SLEEP) && (pwr_next == PWR_RUN);  // R10
    end
  end

endmodule

`default_nettype wire

// ---- src/rpd_pkg.sv ----
package rpd_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] SYSTEM_CONTROL_ADDR  = 32'hFFFF83C8;
  localparam logic [31:0] STANDBY_CONTROL_ADDR = 32'hFFFF8614;
  localparam logic [7:0]  SYSTEM_CONTROL_RST   = 8'h01;
  localparam logic [7:0]  STANDBY_CONTROL_RST  = 8'h1F;
  localparam logic [7:0]  STANDBY_FIXED_BITS   = 8'h1F;   // bit 5 zero, bits 4..0 one
  localparam logic [7:0]  UNMAPPED_READ        = 8'h00;

  // field positions
  localparam int RAM_ENABLE_POS     = 0;
  localparam int STANDBY_SELECT_POS = 7;
  localparam int PORT_FLOAT_POS     = 6;

  // access lengths of the two registers on the internal bus, in states
  localparam int STANDBY_CONTROL_STATES = 3;
  localparam int SYSTEM_CONTROL_STATES  = 2;

  // ---------------------------------------------------------------
  // on-chip ram
  // ---------------------------------------------------------------
  localparam logic [31:0] RAM_BASE_LARGE = 32'hFFFFD800;
  localparam logic [31:0] RAM_BASE_SMALL = 32'hFFFFE800;
  localparam int          RAM_WORDS      = 2560;          // larger variant, 10 kbytes
  localparam int          RAM_IDX_W      = 12;
  localparam logic [31:0] RAM_OFF_DATA   = 32'h00000000;  // value of a read while disabled

  // access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  typedef enum {
    PWR_RUN,
    PWR_SLEEP,
    PWR_SW_STANDBY,
    PWR_OSC_WAIT,
    PWR_HW_STANDBY
  } rpd_pwr_e;

endpackage

// ---- src/rpd_ram_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// ram port between controller and array
interface rpd_ram_if;
  import rpd_pkg::*;
  logic                 en;
  logic                 we;
  logic [3:0]           be;
  logic [RAM_IDX_W-1:0] idx;
  logic [31:0]          wdata;
  logic [31:0]          rdata;

  modport ctl (output en, output we, output be, output idx, output wdata, input rdata);
  modport mem (input en, input we, input be, input idx, input wdata, output rdata);
endinterface

`default_nettype wire

// ---- src/rpd_ram.sv ----
`timescale 1ns/1ns
`default_nettype none

// single-state word array with byte lanes
module rpd_ram
  import rpd_pkg::*;
(
  input  wire logic clk_in,
  rpd_ram_if.mem    port
);

  // -------------------------------------------------------------
  // one byte lane per generate entry, each with its own array
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      logic [7:0] lane_mem_reg [RAM_WORDS];
      logic [7:0] lane_rdata_reg;

      // byte-lane write
      always_ff @(posedge clk_in) begin
        if (port.en && port.we && port.be[g]) begin
          lane_mem_reg[port.idx] <= port.wdata[8*g +: 8];  // R1
        end
      end

      // read answer one cycle after the request, never a wait; idle cycles read zero
      always_ff @(posedge clk_in) begin
        if (port.en && !port.we) begin
          lane_rdata_reg <= lane_mem_reg[port.idx];  // R3
        end else begin
          lane_rdata_reg <= RAM_OFF_DATA[8*g +: 8];  // R5
        end
      end
    end
  endgenerate

  // lanes gathered into the word, lane 3 on top
  assign port.rdata = {g_lane[3].lane_rdata_reg, g_lane[2].lane_rdata_reg,
                       g_lane[1].lane_rdata_reg, g_lane[0].lane_rdata_reg};

endmodule

`default_nettype wire

// ---- verif/rpd_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module rpd_props
  import rpd_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        CPU_REQ_IN,
  input wire logic        HW_STANDBY_N_IN,
  input wire logic        CPU_ACK_OUT,
  input wire logic        DMA_REQ_IN,
  input wire logic [1:0]  DMA_SIZE_IN,
  input wire logic        DMA_SIZE_ERR_OUT,
  input wire logic        CPU_HIT_OUT,
  input wire logic        DMA_ACK_OUT,
  input wire logic [31:0] RAM_RDATA_OUT,
  input wire logic        SLEEP_IN,
  input wire logic [2:0]  PWR_MODE_OUT,
  input wire logic        CPU_HALT_OUT,
  input wire logic        CHIP_CLK_RUN_OUT,
  input wire logic        PERIPH_RUN_OUT,
  input wire logic        RAM_RETAIN_OUT,
  input wire logic        PORT_INIT_OUT,
  input wire logic        WDT_OVF_IN,
  input wire logic        NMI_START_OUT,
  input wire logic        REG_RD_IN,
  input wire logic [7:0]  REG_RDATA_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ram ports, register port and mode sequencing
  a_cpu_one_state: assert property (CPU_REQ_IN && PWR_MODE_OUT == 3'h0 && HW_STANDBY_N_IN
    |=> CPU_ACK_OUT) else $error("cpu access late");
  a_dma_long_refused: assert property (DMA_REQ_IN && DMA_SIZE_IN == SIZE_LONG && !CPU_REQ_IN
    && PWR_MODE_OUT == 3'h0 && HW_STANDBY_N_IN |=> DMA_SIZE_ERR_OUT && !DMA_ACK_OUT)
    else $error("dma long taken");
  a_miss_reads_zero: assert property (!CPU_HIT_OUT && !DMA_ACK_OUT |-> RAM_RDATA_OUT == 32'h0)
    else $error("miss data nonzero");
  a_sleep_entry: assert property (SLEEP_IN && PWR_MODE_OUT == 3'h0 && HW_STANDBY_N_IN
    |=> PWR_MODE_OUT inside {3'h1, 3'h2} && CPU_HALT_OUT) else $error("sleep not entered");
  a_standby_halts: assert property (PWR_MODE_OUT == 3'h2
    |-> !CHIP_CLK_RUN_OUT && !PERIPH_RUN_OUT && RAM_RETAIN_OUT) else $error("standby runs");
  a_hw_pin_entry: assert property (!HW_STANDBY_N_IN |=> PWR_MODE_OUT == 3'h4 && PORT_INIT_OUT)
    else $error("hw standby missed");
  a_hw_only_reset: assert property (PWR_MODE_OUT == 3'h4 |=> PWR_MODE_OUT == 3'h4)
    else $error("hw standby left");
  a_nmi_resume: assert property (PWR_MODE_OUT == 3'h3 && WDT_OVF_IN && HW_STANDBY_N_IN
    |=> PWR_MODE_OUT == 3'h0 && NMI_START_OUT && !$past(NMI_START_OUT)) else $error("no resume");
  a_rdata_once: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
    else $error("read data stays");
endmodule
bind rpd_top rpd_props u_props (.CLK_IN, .RST_IN, .CPU_REQ_IN, .HW_STANDBY_N_IN, .CPU_ACK_OUT,
  .DMA_REQ_IN, .DMA_SIZE_IN, .DMA_SIZE_ERR_OUT, .CPU_HIT_OUT, .DMA_ACK_OUT, .RAM_RDATA_OUT,
  .SLEEP_IN, .PWR_MODE_OUT, .CPU_HALT_OUT, .CHIP_CLK_RUN_OUT, .PERIPH_RUN_OUT, .RAM_RETAIN_OUT,
  .PORT_INIT_OUT, .WDT_OVF_IN, .NMI_START_OUT, .REG_RD_IN, .REG_RDATA_OUT);
`default_nettype wire

// ---- verif/rpd_dma_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module rpd_dma_model (
  input  wire logic        clk_in,
  output logic             req_out = 1'b0,
  output logic             we_out = 1'b0,
  output logic [1:0]       size_out = 2'h0,
  output logic [31:0]      addr_out = 32'h0,
  output logic [31:0]      wdata_out = 32'h0
);
  // one-state transfer, held to the taking edge, bus shows junk after release
  task automatic xfer(input logic w, input logic [1:0] s, input logic [31:0] a, d);
    @(posedge clk_in);
    req_out <= 1'b1;
    we_out <= w;
    size_out <= s;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    req_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- verif/test_ram_enable_and_power_down_control.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_ram_enable_and_power_down_control;
  import rpd_pkg::*;
  localparam logic [31:0] B = RAM_BASE_LARGE;
  logic        CLK_IN = 1'b0, RST_IN = 1'b1;
  logic [31:0] REG_ADDR_IN = 32'h0, CPU_ADDR_IN = 32'h0, CPU_WDATA_IN = 32'h0;
  logic [7:0]  REG_WDATA_IN = 8'h00;
  logic        REG_WR_IN = 1'b0, REG_RD_IN = 1'b0, CPU_REQ_IN = 1'b0, CPU_WE_IN = 1'b0;
  logic [1:0]  CPU_SIZE_IN = 2'h0;
  logic        HW_STANDBY_N_IN = 1'b1, WDT_RUN_IN = 1'b0, SLEEP_IN = 1'b0, IRQ_IN = 1'b0;
  logic        DMA_ADDR_ERR_IN = 1'b0, NMI_EDGE_IN = 1'b0, WDT_OVF_IN = 1'b0;
  wire logic   DMA_REQ_IN, DMA_WE_IN;
  wire logic [1:0]  DMA_SIZE_IN;
  wire logic [31:0] DMA_ADDR_IN, DMA_WDATA_IN;
  logic [7:0]  REG_RDATA_OUT;
  logic [31:0] RAM_RDATA_OUT;
  logic [2:0]  PWR_MODE_OUT;
  logic CPU_ACK_OUT, CPU_HIT_OUT, DMA_ACK_OUT, DMA_SIZE_ERR_OUT, CPU_HALT_OUT, CHIP_CLK_RUN_OUT;
  logic WDT_CLK_RUN_OUT, PERIPH_RUN_OUT, OSC_RUN_OUT, PORT_FLOAT_OUT, PORT_INIT_OUT;
  logic RAM_RETAIN_OUT, NMI_START_OUT, WAKE_START_OUT;
  int   error_cnt = 0, compares = 0;

  rpd_top #(.LARGE_VARIANT(1'b1)) u_dut (.*);
  rpd_dma_model u_dma (.clk_in(CLK_IN), .req_out(DMA_REQ_IN), .we_out(DMA_WE_IN),
    .size_out(DMA_SIZE_IN), .addr_out(DMA_ADDR_IN), .wdata_out(DMA_WDATA_IN));

  // clock, 50 ns period
  always #25 CLK_IN = ~CLK_IN;

  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b1;
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= d;
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b1;
    REG_ADDR_IN <= a;
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b0;
    #1 chk("reg read", REG_RDATA_OUT, e);
  endtask
  task automatic cpu(input logic w, input logic [1:0] s, input logic [31:0] a, d);
    @(posedge CLK_IN);
    CPU_REQ_IN <= 1'b1;
    CPU_WE_IN <= w;
    CPU_SIZE_IN <= s;
    CPU_ADDR_IN <= a;
    CPU_WDATA_IN <= d;
    @(posedge CLK_IN);
    CPU_REQ_IN <= 1'b0;
    #1;
  endtask
  task automatic dma(input logic w, input logic [1:0] s, input logic [31:0] a, d);
    u_dma.xfer(w, s, a, d);
    #1;
  endtask
  // one-cycle pulse of {sleep, irq, dma error, nmi, overflow}
  task automatic step(input logic [4:0] p);
    @(posedge CLK_IN);
    {SLEEP_IN, IRQ_IN, DMA_ADDR_ERR_IN, NMI_EDGE_IN, WDT_OVF_IN} <= p;
    @(posedge CLK_IN);
    {SLEEP_IN, IRQ_IN, DMA_ADDR_ERR_IN, NMI_EDGE_IN, WDT_OVF_IN} <= 5'h00;
    #1;
  endtask

  task automatic t_regs;
    rdc(SYSTEM_CONTROL_ADDR, 8'h01);
    rdc(STANDBY_CONTROL_ADDR, 8'h1F);
    rdc(32'hFFFF8000, 8'h00);
    wr(SYSTEM_CONTROL_ADDR, 8'hFE);
    rdc(SYSTEM_CONTROL_ADDR, 8'h00);
    wr(SYSTEM_CONTROL_ADDR, 8'h01);
    rdc(SYSTEM_CONTROL_ADDR, 8'h01);
    @(posedge CLK_IN) WDT_RUN_IN <= 1'b1;
    wr(STANDBY_CONTROL_ADDR, 8'hC0);
    rdc(STANDBY_CONTROL_ADDR, 8'h1F);
    @(posedge CLK_IN) WDT_RUN_IN <= 1'b0;
    wr(STANDBY_CONTROL_ADDR, 8'hE0);
    rdc(STANDBY_CONTROL_ADDR, 8'hDF);
    @(posedge CLK_IN) WDT_RUN_IN <= 1'b1;
    wr(STANDBY_CONTROL_ADDR, 8'h1F);
    rdc(STANDBY_CONTROL_ADDR, 8'h1F);
    @(posedge CLK_IN) WDT_RUN_IN <= 1'b0;
  endtask
  task automatic t_ram;
    cpu(1'b1, SIZE_LONG, B, 32'h11223344);
    chk("cpu ack", CPU_ACK_OUT, 32'h1);
    cpu(1'b1, SIZE_BYTE, B + 1, 32'h00AA0000);
    cpu(1'b1, SIZE_WORD, B + 2, 32'h0000BEEF);
    cpu(1'b1, SIZE_LONG, B + 4, 32'h0);
    cpu(1'b0, SIZE_LONG, B, 32'h0);
    chk("ram word", RAM_RDATA_OUT, 32'h11AABEEF);
    chk("cpu hit", CPU_HIT_OUT, 32'h1);
    cpu(1'b0, SIZE_LONG, B - 4, 32'h0);
    chk("below base", CPU_HIT_OUT, 32'h0);
    dma(1'b1, SIZE_WORD, B + 4, 32'h12340000);
    chk("dma ack", DMA_ACK_OUT, 32'h1);
    dma(1'b0, SIZE_BYTE, B, 32'h0);
    chk("dma read", RAM_RDATA_OUT, 32'h11AABEEF);
    dma(1'b0, SIZE_LONG, B, 32'h0);
    chk("dma long", DMA_SIZE_ERR_OUT, 32'h1);
    cpu(1'b0, SIZE_LONG, B + 4, 32'h0);
    chk("dma word", RAM_RDATA_OUT, 32'h12340000);
  endtask
  task automatic t_off;
    wr(SYSTEM_CONTROL_ADDR, 8'h00);
    rdc(SYSTEM_CONTROL_ADDR, 8'h00);
    cpu(1'b1, SIZE_LONG, B, 32'h55555555);
    cpu(1'b0, SIZE_LONG, B, 32'h0);
    chk("off hit", CPU_HIT_OUT, 32'h0);
    chk("off data", RAM_RDATA_OUT, RAM_OFF_DATA);
    wr(SYSTEM_CONTROL_ADDR, 8'h01);
    rdc(SYSTEM_CONTROL_ADDR, 8'h01);
    cpu(1'b0, SIZE_LONG, B, 32'h0);
    chk("write ignored", RAM_RDATA_OUT, 32'h11AABEEF);
  endtask
  task automatic t_sleep;
    for (int i = 0; i < 2; i++) begin
      step(5'h10);
      chk("sleep", {PWR_MODE_OUT, CPU_HALT_OUT, PERIPH_RUN_OUT}, 5'h07);
      step(5'h02);
      chk("nmi in sleep", PWR_MODE_OUT, 3'h1);
      step(i ? 5'h04 : 5'h08);
      chk("sleep exit", {PWR_MODE_OUT, WAKE_START_OUT}, 4'h1);
    end
  endtask
  task automatic t_sw;
    for (int i = 0; i < 2; i++) begin
      wr(STANDBY_CONTROL_ADDR, i ? 8'h9F : 8'hDF);
      step(5'h10);
      chk("sw standby", PWR_MODE_OUT, 3'h2);
      chk("float", PORT_FLOAT_OUT, i ? 32'h0 : 32'h1);
      step(5'h08);
      chk("irq ignored", PWR_MODE_OUT, 3'h2);
      step(5'h02);
      chk("osc wait", {PWR_MODE_OUT, WDT_CLK_RUN_OUT, CHIP_CLK_RUN_OUT}, 5'h0E);
      step(5'h01);
      chk("wake", {PWR_MODE_OUT, NMI_START_OUT}, 4'h1);
    end
    cpu(1'b0, SIZE_LONG, B, 32'h0);
    chk("held", RAM_RDATA_OUT, 32'h11AABEEF);
  endtask
  task automatic t_hw;
    wr(SYSTEM_CONTROL_ADDR, 8'h00);
    rdc(SYSTEM_CONTROL_ADDR, 8'h00);
    @(posedge CLK_IN) HW_STANDBY_N_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    #1 chk("hw", {PWR_MODE_OUT, PORT_INIT_OUT, RAM_RETAIN_OUT}, 5'h13);
    @(posedge CLK_IN) HW_STANDBY_N_IN <= 1'b1;
    repeat (3) @(posedge CLK_IN);
    #1 chk("pin high", {PWR_MODE_OUT, OSC_RUN_OUT}, 4'h9);
    @(posedge CLK_IN) RST_IN <= 1'b1;
    repeat (3) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    rdc(SYSTEM_CONTROL_ADDR, 8'h01);
    cpu(1'b0, SIZE_LONG, B, 32'h0);
    chk("after hw", RAM_RDATA_OUT, 32'h11AABEEF);
  endtask

  task wrap_up;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    t_regs;
    t_ram;
    t_off;
    t_sleep;
    t_sw;
    t_hw;
    wrap_up;
  end
  // watchdog, far beyond the roughly 120 cycles of the tests
  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
